/* File: hdl/dfc_pkg.sv */
package dfc_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_KHZ = 125000;
  localparam int BULB_MS = 5000;
  localparam int SHUT_MS = 30000;
  localparam int EMPTY_MS = 3000;
  localparam int ON_MS = 400;
  localparam int OFF_MS = 400;
  localparam int DGAP_MS = 1200;
  localparam int CGAP_MS = 2400;
  localparam logic [31:0] BULB_CYC = 32'(64'(BULB_MS) * 64'(CLK_KHZ));
  localparam logic [31:0] SHUT_CYC = 32'(64'(SHUT_MS) * 64'(CLK_KHZ));
  localparam logic [31:0] EMPTY_CYC = 32'(64'(EMPTY_MS) * 64'(CLK_KHZ));
  localparam logic [31:0] ON_CYC = 32'(64'(ON_MS) * 64'(CLK_KHZ));
  localparam logic [31:0] OFF_CYC = 32'(64'(OFF_MS) * 64'(CLK_KHZ));
  localparam logic [31:0] DGAP_CYC = 32'(64'(DGAP_MS) * 64'(CLK_KHZ));
  localparam logic [31:0] CGAP_CYC = 32'(64'(CGAP_MS) * 64'(CLK_KHZ));
  // ------------------------------------------------------------
  // Code memory and fields
  // ------------------------------------------------------------
  localparam int DEPTH = 8;
  localparam int IDX_W = 3;
  localparam int CODE_W = 16;
  localparam int SENS_W = 12;
  localparam logic [IDX_W-1:0] LAST_IDX = 3'h7;
  localparam logic [IDX_W:0] DEPTH_CNT = 4'h8;
  localparam logic [1:0] LAST_DIGIT = 2'h3;
  localparam logic [3:0] ZERO_PULSES = 4'hA;
  localparam logic [CODE_W-1:0] EMPTY_CODE = 16'h0003;
  localparam logic [SENS_W-1:0] SENSOR_DEFAULT = 12'h800;
  typedef enum logic [2:0] {
    S_IDLE, S_FIND, S_LOAD, S_ON, S_OFF, S_GAP
  } dfc_state_t;
endpackage

/* File: hdl/dfc_flash_code.sv */
module dfc_flash_code
  import dfc_pkg::*;
#(
  parameter logic [31:0] P_BULB = BULB_CYC,
  parameter logic [31:0] P_SHUT = SHUT_CYC,
  parameter logic [31:0] P_ON = ON_CYC,
  parameter logic [31:0] P_OFF = OFF_CYC,
  parameter logic [31:0] P_DGAP = DGAP_CYC,
  parameter logic [31:0] P_CGAP = CGAP_CYC,
  parameter logic [31:0] P_EMPTY = EMPTY_CYC
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RSTN,
  input wire logic I_FAULT_SET,
  input wire logic I_FAULT_GONE,
  input wire logic I_FAULT_MAJOR,
  input wire logic [CODE_W-1:0] I_FAULT_CODE,
  input wire logic I_READER_CLEAR,
  input wire logic I_OVERRIDE_SW,
  input wire logic I_IGN_ON,
  input wire logic I_ENGINE_IDLE_OR_STOP,
  input wire logic I_REAR_START_NORMAL,
  input wire logic I_SENSOR_FAIL,
  input wire logic [SENS_W-1:0] I_SENSOR_VALUE,
  output logic O_CHECK_LAMP,
  output logic O_STOP_LAMP,
  output logic O_SHUTDOWN,
  output logic O_DIAG_RUN,
  output logic [SENS_W-1:0] O_SENSOR_VALUE
);
  // ------------------------------------------------------------
  // Code memory, newest entry at index 0
  // ------------------------------------------------------------
  logic [CODE_W-1:0] e_code [DEPTH];
  logic [DEPTH-1:0] e_used;
  logic [DEPTH-1:0] e_act;
  logic [DEPTH-1:0] e_maj;
  logic [DEPTH-1:0] hit;
  logic [CODE_W-1:0] sh_code [DEPTH+1];
  wire [DEPTH:0] sh_used = {e_used, 1'b1};
  wire [DEPTH:0] sh_act = {e_act, 1'b1};
  wire [DEPTH:0] sh_maj = {e_maj, I_FAULT_MAJOR};
  wire any_hit = |hit;
  wire ins = I_FAULT_SET && (I_READER_CLEAR || !any_hit);
  wire any_act = |(e_used & e_act);
  wire major_on = |(e_used & e_act & e_maj);
  assign sh_code[0] = I_FAULT_CODE;
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_ent
      assign hit[i] = e_used[i] && (e_code[i] == I_FAULT_CODE);
      assign sh_code[i+1] = e_code[i];
      always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
          e_code[i] <= '0;
          e_used[i] <= 1'b0;
          e_act[i] <= 1'b0;
          e_maj[i] <= 1'b0;
        end else if (ins && (i == 0 || !I_READER_CLEAR)) begin
          e_code[i] <= sh_code[i];
          e_used[i] <= sh_used[i];
          e_act[i] <= sh_act[i];
          e_maj[i] <= sh_maj[i];
        end else if (I_READER_CLEAR) begin
          e_used[i] <= 1'b0;
          e_act[i] <= 1'b0;
          e_maj[i] <= 1'b0;
        end else if (I_FAULT_SET && hit[i]) begin
          e_act[i] <= 1'b1;
          e_maj[i] <= e_maj[i] | I_FAULT_MAJOR;
        end else if (I_FAULT_GONE && hit[i]) begin
          e_act[i] <= 1'b0;
        end
      end
    end
  endgenerate
  // ------------------------------------------------------------
  // Switch, bulb check and shutdown delay
  // ------------------------------------------------------------
  logic sw_q;
  logic [31:0] bulb_cnt;
  logic [31:0] shut_cnt;
  logic rd;
  wire press = I_OVERRIDE_SW && !sw_q;
  wire ovr_press = press && major_on;
  wire bulb = bulb_cnt != P_BULB;
  wire rd_ok = I_IGN_ON && I_ENGINE_IDLE_OR_STOP && I_REAR_START_NORMAL;
  wire rd_start = !rd && press && !major_on && rd_ok;
  wire rd_stop = rd && (press || !rd_ok);
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RSTN) begin
      sw_q <= 1'b0;
      bulb_cnt <= '0;
    end else begin
      sw_q <= I_OVERRIDE_SW;
      if (bulb) begin
        bulb_cnt <= bulb_cnt + 32'h1;
      end
    end
  end
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RSTN || !major_on) begin
      shut_cnt <= '0;
      O_SHUTDOWN <= 1'b0;
    end else if (!O_SHUTDOWN) begin
      if (ovr_press) begin
        shut_cnt <= '0;
      end else if (shut_cnt == P_SHUT - 32'h1) begin
        O_SHUTDOWN <= 1'b1;
      end else begin
        shut_cnt <= shut_cnt + 32'h1;
      end
    end
  end
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RSTN) begin
      rd <= 1'b0;
    end else if (rd_stop) begin
      rd <= 1'b0;
    end else if (rd_start) begin
      rd <= 1'b1;
    end
  end
  // ------------------------------------------------------------
  // Readout sequencer
  // ------------------------------------------------------------
  dfc_state_t st;
  logic list;
  logic single;
  logic rep;
  logic nxt;
  logic have_last;
  logic found;
  logic [1:0] digit;
  logic [3:0] pulses;
  logic [31:0] tmr;
  logic [IDX_W-1:0] scan;
  logic [IDX_W:0] pos;
  logic [CODE_W-1:0] cur;
  logic [CODE_W-1:0] last;
  logic [CODE_W-1:0] best;
  wire cand = e_used[scan] && e_act[scan]
              && (!have_last || e_code[scan] > last);
  wire take = cand && (!found || e_code[scan] < best);
  wire fnd = found || cand;
  wire [CODE_W-1:0] bst = take ? e_code[scan] : best;
  wire scan_end = scan == LAST_IDX;
  wire inact_ok = (pos < DEPTH_CNT) && e_used[pos[IDX_W-1:0]];
  wire show_act = !list && fnd && !single;
  wire show_ina = list && inact_ok && !single;
  wire show_code = show_act || show_ina;
  wire show_emp = !single && !show_code
                  && (list ? (pos == '0) : !have_last);
  wire [CODE_W-1:0] pick = list ? e_code[pos[IDX_W-1:0]] : bst;
  wire [3:0] dig_val = cur[{digit, 2'b00} +: 4];
  wire tmr_end = tmr == '0;
  // Only control state is cleared; data regs are loaded before use
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RSTN || !rd) begin
      st <= S_IDLE;
      list <= 1'b0;
      single <= 1'b0;
      have_last <= 1'b0;
      found <= 1'b0;
      scan <= '0;
      pos <= '0;
    end else begin
      case (st)
        S_IDLE: begin
          st <= S_FIND;
        end
        S_FIND: begin
          scan <= scan + 3'h1;
          found <= fnd;
          best <= bst;
          if (scan_end) begin
            found <= 1'b0;
            if (show_code || show_emp) begin
              cur <= show_emp ? EMPTY_CODE : pick;
              single <= show_emp;
              rep <= 1'b0;
              digit <= show_emp ? 2'h0 : LAST_DIGIT;
              st <= S_LOAD;
              if (show_act) begin
                last <= bst;
                have_last <= 1'b1;
              end
              if (show_ina) begin
                pos <= pos + 4'h1;
              end
            end else begin
              list <= ~list;
              pos <= '0;
              have_last <= 1'b0;
              single <= 1'b0;
            end
          end
        end
        S_LOAD: begin
          pulses <= (dig_val == 4'h0) ? ZERO_PULSES : dig_val;
          tmr <= P_ON - 32'h1;
          st <= S_ON;
        end
        S_ON: begin
          tmr <= tmr - 32'h1;
          if (tmr_end) begin
            tmr <= P_OFF - 32'h1;
            pulses <= pulses - 4'h1;
            st <= S_OFF;
          end
        end
        S_OFF: begin
          tmr <= tmr - 32'h1;
          if (tmr_end && pulses != 4'h0) begin
            tmr <= P_ON - 32'h1;
            st <= S_ON;
          end else if (tmr_end) begin
            st <= S_GAP;
            if (digit != 2'h0) begin
              digit <= digit - 2'h1;
              nxt <= 1'b0;
              tmr <= P_DGAP - 32'h1;
            end else if (!single && !rep) begin
              rep <= 1'b1;
              digit <= LAST_DIGIT;
              nxt <= 1'b0;
              tmr <= P_CGAP - 32'h1;
            end else begin
              nxt <= 1'b1;
              tmr <= single ? P_EMPTY - 32'h1 : P_CGAP - 32'h1;
            end
          end
        end
        S_GAP: begin
          tmr <= tmr - 32'h1;
          if (tmr_end) begin
            st <= nxt ? S_FIND : S_LOAD;
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end
  // ------------------------------------------------------------
  // Lamps and sensor substitution
  // ------------------------------------------------------------
  wire blink = st == S_ON;
  wire next_check = rd ? (list && blink) : (bulb || any_act);
  wire next_stop = rd ? (!list && blink) : (bulb || major_on);
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RSTN) begin
      O_CHECK_LAMP <= 1'b0;
      O_STOP_LAMP <= 1'b0;
      O_DIAG_RUN <= 1'b0;
      O_SENSOR_VALUE <= '0;
    end else begin
      O_CHECK_LAMP <= next_check;
      O_STOP_LAMP <= next_stop;
      O_DIAG_RUN <= 1'b1;
      O_SENSOR_VALUE <= I_SENSOR_FAIL ? SENSOR_DEFAULT
                                      : I_SENSOR_VALUE;
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RSTN);
  a_fault_check_lamp: assert property (
    I_FAULT_SET && !rd && !rd_start |=> ##1 (O_CHECK_LAMP || rd))
    else $error("check lamp not lit after fault");
  a_major_stop_lamp: assert property (
    I_FAULT_SET && I_FAULT_MAJOR && !rd && !rd_start
    |=> ##1 (O_STOP_LAMP || rd))
    else $error("stop lamp not lit after major fault");
  a_bulb_lamps_on: assert property (
    bulb && !rd |=> O_CHECK_LAMP && O_STOP_LAMP)
    else $error("bulb check lamps off");
  a_stop_cause: assert property (
    O_STOP_LAMP |-> $past(major_on || bulb || rd))
    else $error("stop lamp without cause");
  a_override_restart: assert property (
    ovr_press && !O_SHUTDOWN |=> shut_cnt == '0 && !O_SHUTDOWN)
    else $error("override did not restart delay");
  a_late_press_held: assert property (
    O_SHUTDOWN && major_on |=> O_SHUTDOWN)
    else $error("shutdown withdrawn after expiry");
  a_readout_gate: assert property (
    $rose(rd) |-> $past(I_IGN_ON && I_ENGINE_IDLE_OR_STOP && !major_on))
    else $error("readout started out of conditions");
  a_rear_normal: assert property (
    $rose(rd) |-> $past(I_REAR_START_NORMAL))
    else $error("readout with rear start selected");
  a_active_first: assert property (
    $rose(rd) |-> ##1 (st == S_FIND && !list))
    else $error("readout did not begin with active list");
  a_code_twice: assert property (
    st == S_GAP && nxt && !single |-> rep)
    else $error("code shown only once");
  a_ascending: assert property (
    st == S_FIND && scan_end && show_act && have_last |-> bst > last)
    else $error("active codes out of order");
  a_empty_pause: assert property (
    st == S_OFF && tmr_end && pulses == 4'h0 && single && digit == 2'h0
    |=> st == S_GAP && tmr == P_EMPTY - 32'h1)
    else $error("empty list pause wrong");
  a_keep_codes: assert property (
    e_used != '0 && !I_READER_CLEAR |=> e_used != '0)
    else $error("codes lost without reader clear");
  a_sensor_subst: assert property (
    I_SENSOR_FAIL |=> O_SENSOR_VALUE == SENSOR_DEFAULT)
    else $error("failed sensor not substituted");
  c_readout: cover property ($rose(rd) ##[1:50] st == S_ON);
  c_override: cover property (ovr_press && !O_SHUTDOWN);
  c_shutdown: cover property ($rose(O_SHUTDOWN));
  c_empty: cover property (st == S_FIND && scan_end && show_emp);
endmodule

/* File: verif/dfc_operator.sv */
module dfc_operator #(
  parameter int GAP_LIMIT = 3
) (
  input wire logic i_clk,
  input wire logic i_check,
  input wire logic i_stop,
  output logic o_sw
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Lamp pulses grouped into digits, stop lamp entries offset 256
  // ------------------------------------------------------------
  int digits[$];
  int low_cnt = 100;
  logic prev_on = 1'b0;
  logic prev_stop = 1'b0;
  wire logic lamp_on = i_check | i_stop;
  initial o_sw = 1'b0;
  always @(posedge i_clk) begin
    if (lamp_on && !prev_on) begin
      if (low_cnt > GAP_LIMIT || i_stop !== prev_stop || digits.size() == 0)
        digits.push_back(i_stop ? 256 : 0);
      digits[$] = digits[$] + 1;
      prev_stop <= i_stop;
    end
    low_cnt <= lamp_on ? 0 : low_cnt + 1;
    prev_on <= lamp_on;
  end
  // ------------------------------------------------------------
  // Operator push-button
  // ------------------------------------------------------------
  task automatic press();
    @(posedge i_clk);
    o_sw <= 1'b1;
    repeat (3) @(posedge i_clk);
    o_sw <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
endmodule

/* File: verif/test_dfc_flash_code.sv */
module test_dfc_flash_code
  import dfc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] T_BULB = 32'h14;
  localparam logic [31:0] T_SHUT = 32'h28;
  logic clk, rstn, fset, fgone, fmaj, rclr, sw, ign, idle, rear, sfail;
  logic [CODE_W-1:0] fcode;
  logic [SENS_W-1:0] sval, sout;
  logic chk_l, stp_l, shut, diag;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int exp_q[$];
  dfc_flash_code #(.P_BULB(T_BULB), .P_SHUT(T_SHUT), .P_ON(32'h2),
    .P_OFF(32'h2), .P_DGAP(32'h6), .P_CGAP(32'hA), .P_EMPTY(32'hC)) uut (
    .I_CLK_SYS(clk), .I_RSTN(rstn), .I_FAULT_SET(fset),
    .I_FAULT_GONE(fgone), .I_FAULT_MAJOR(fmaj), .I_FAULT_CODE(fcode),
    .I_READER_CLEAR(rclr), .I_OVERRIDE_SW(sw), .I_IGN_ON(ign),
    .I_ENGINE_IDLE_OR_STOP(idle), .I_REAR_START_NORMAL(rear),
    .I_SENSOR_FAIL(sfail), .I_SENSOR_VALUE(sval), .O_CHECK_LAMP(chk_l),
    .O_STOP_LAMP(stp_l), .O_SHUTDOWN(shut), .O_DIAG_RUN(diag),
    .O_SENSOR_VALUE(sout));
  dfc_operator #(.GAP_LIMIT(3)) op (.i_clk(clk), .i_check(chk_l),
    .i_stop(stp_l), .o_sw(sw));
  // ------------------------------------------------------------
  // Compare and report
  // ------------------------------------------------------------
  task automatic chk_bit(logic got, logic want);
    num_checks++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected at %0t: bit %b want %b", $time, got, want);
    end
  endtask
  task automatic chk_val(logic [SENS_W-1:0] got, logic [SENS_W-1:0] want);
    num_checks++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected at %0t: value %h want %h", $time, got, want);
    end
  endtask
  task automatic chk_int(int got, int want);
    num_checks++;
    if (got != want) begin
      mismatches++;
      $display("unexpected at %0t: digit %0d want %0d", $time, got, want);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic fault(logic [15:0] code, logic maj, logic gone);
    @(posedge clk);
    fcode <= code;
    fmaj <= maj;
    fset <= !gone;
    fgone <= gone;
    @(posedge clk);
    fset <= 1'b0;
    fgone <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic add_code(int lamp, logic [15:0] code);
    logic [3:0] n;
    for (int c = 0; c < 2; c++) begin
      for (int d = 3; d >= 0; d--) begin
        n = code[d*4+:4];
        exp_q.push_back(lamp + ((n == 4'h0) ? 10 : int'(n)));
      end
    end
  endtask
  task automatic run_readout();
    int w;
    w = 0;
    op.digits.delete();
    op.press();
    while (op.digits.size() <= exp_q.size() && w < 4000) begin
      @(posedge clk);
      w++;
    end
    for (int i = 0; i < exp_q.size(); i++)
      chk_int((i < op.digits.size()) ? op.digits[i] : -1, exp_q[i]);
    op.press();
    repeat (4) @(posedge clk);
    #1;
    exp_q.delete();
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_bulb();
    repeat (2) @(posedge clk);
    #1;
    chk_bit(chk_l, 1'b1);
    chk_bit(stp_l, 1'b1);
    chk_bit(diag, 1'b1);
    repeat (T_BULB + 2) @(posedge clk);
    #1;
    chk_bit(chk_l, 1'b0);
    chk_bit(stp_l, 1'b0);
    chk_bit(diag, 1'b1);
  endtask
  task automatic t_sensor();
    @(posedge clk);
    sfail <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk_val(sout, SENSOR_DEFAULT);
    @(posedge clk);
    sfail <= 1'b0;
    sval <= 12'h456;
    repeat (2) @(posedge clk);
    #1;
    chk_val(sout, 12'h456);
  endtask
  task automatic t_minor();
    fault(16'h1111, 1'b0, 1'b0);
    chk_bit(chk_l, 1'b1);
    chk_bit(stp_l, 1'b0);
    fault(16'h2130, 1'b0, 1'b0);
  endtask
  task automatic t_gate();
    for (int g = 0; g < 3; g++) begin
      @(posedge clk);
      idle <= (g != 0);
      rear <= (g != 1);
      ign <= (g != 2);
      op.digits.delete();
      op.press();
      repeat (40) @(posedge clk);
      #1;
      chk_int(op.digits.size(), 0);
      chk_bit(chk_l, 1'b1);
      @(posedge clk);
      idle <= 1'b1;
      rear <= 1'b1;
      ign <= 1'b1;
    end
  endtask
  task automatic t_readout();
    add_code(256, 16'h1111);
    add_code(256, 16'h2130);
    add_code(0, 16'h2130);
    add_code(0, 16'h1111);
    exp_q.push_back(257);
    run_readout();
    chk_bit(chk_l, 1'b1);
    chk_bit(stp_l, 1'b0);
  endtask
  task automatic t_major();
    fault(16'h3333, 1'b1, 1'b0);
    chk_bit(stp_l, 1'b1);
    chk_bit(chk_l, 1'b1);
    repeat (T_SHUT / 2) @(posedge clk);
    op.press();
    repeat (T_SHUT - 10) @(posedge clk);
    #1;
    chk_bit(shut, 1'b0);
    repeat (10) @(posedge clk);
    #1;
    chk_bit(shut, 1'b1);
    op.press();
    repeat (10) @(posedge clk);
    #1;
    chk_bit(shut, 1'b1);
    fault(16'h3333, 1'b0, 1'b1);
    chk_bit(shut, 1'b0);
    chk_bit(stp_l, 1'b0);
  endtask
  task automatic t_clear();
    fault(16'h1111, 1'b0, 1'b1);
    fault(16'h2130, 1'b0, 1'b1);
    chk_bit(chk_l, 1'b0);
    @(posedge clk);
    rclr <= 1'b1;
    @(posedge clk);
    rclr <= 1'b0;
    exp_q = '{259, 3, 259};
    run_readout();
  endtask
  // ------------------------------------------------------------
  // Clock, timeout and main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    rstn = 1'b0; fset = 1'b0; fgone = 1'b0; fmaj = 1'b0; rclr = 1'b0;
    fcode = 16'h0000; ign = 1'b1; idle = 1'b1; rear = 1'b1;
    sfail = 1'b0; sval = 12'h123;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_bulb();
    t_sensor();
    t_minor();
    t_gate();
    t_readout();
    t_major();
    t_clear();
    summarize();
  end
endmodule
